//--- design/csc_ctrl_rx.sv
// serial control receiver holding the format and output control register
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"

module csc_ctrl_rx
	import csc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       addr_sel,
	output logic            sda_out,
	output logic            sda_oe,
	output logic [7:0]      ctrl
);

	rx_regs_t r_reg;
	rx_regs_t r_next;
	logic     rise;
	logic     fall;
	logic     start;
	logic     stop;
	logic     byte_done;

	// bus events seen only after the two-stage synchronisers
	assign rise      = r_reg.scl_s2 & ~r_reg.scl_s3;
	assign fall      = ~r_reg.scl_s2 & r_reg.scl_s3;
	assign start     = r_reg.scl_s2 & r_reg.scl_s3 & r_reg.sda_s3
		& ~r_reg.sda_s2;
	assign stop      = r_reg.scl_s2 & r_reg.scl_s3 & ~r_reg.sda_s3
		& r_reg.sda_s2;
	assign byte_done = fall && (r_reg.cnt == `CSC_BYTE_BITS);

	// next state of the receiver; write-only, reads are not acknowledged
	always_comb begin
		r_next        = r_reg;
		r_next.scl_s1 = scl_in;
		r_next.scl_s2 = r_reg.scl_s1;
		r_next.scl_s3 = r_reg.scl_s2;
		r_next.sda_s1 = sda_in;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.sda_s3 = r_reg.sda_s2;
		r_next.adr_s1 = addr_sel;
		r_next.adr_s2 = r_reg.adr_s1;
		if (rise && r_reg.cnt < `CSC_BYTE_BITS && (r_reg.state == RX_ADDR
			|| r_reg.state == RX_SUB || r_reg.state == RX_DATA)) begin
			r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
			r_next.cnt   = r_reg.cnt + 4'h1;
		end
		unique case (r_reg.state)
			RX_IDLE: ;
			RX_ADDR: if (byte_done) begin
				r_next.cnt   = 4'h0;
				r_next.state = (r_reg.shift == {`CSC_SLV_BASE,
					r_reg.adr_s2, 1'b0}) ? RX_ACK_A : RX_IDLE;
			end
			RX_ACK_A: if (fall)
				r_next.state = RX_SUB;
			RX_SUB: if (byte_done) begin
				r_next.cnt   = 4'h0;
				r_next.sub   = r_reg.shift;
				r_next.state = RX_ACK_S;
			end
			RX_ACK_S: if (fall)
				r_next.state = RX_DATA;
			RX_DATA: if (byte_done) begin
				r_next.cnt   = 4'h0;
				if (r_reg.sub == `CSC_SUB_CTRL)
					r_next.ctrl = r_reg.shift;
				r_next.sub   = r_reg.sub + 8'h01;
				r_next.state = RX_ACK_D;
			end
			RX_ACK_D: if (fall)
				r_next.state = RX_DATA;
			default: r_next.state = RX_IDLE;
		endcase
		// start and stop override any byte in progress
		if (start) begin
			r_next.state = RX_ADDR;
			r_next.cnt   = 4'h0;
		end else if (stop) begin
			r_next.state = RX_IDLE;
		end
	end

	// reset loads the documented control defaults
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg       <= '0;
			r_reg.scl_s1 <= 1'b1;
			r_reg.scl_s2 <= 1'b1;
			r_reg.scl_s3 <= 1'b1;
			r_reg.sda_s1 <= 1'b1;
			r_reg.sda_s2 <= 1'b1;
			r_reg.sda_s3 <= 1'b1;
			r_reg.ctrl  <= `CSC_CTRL_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// acknowledge by pulling the data line low
	assign sda_out = 1'b0;
	assign sda_oe  = (r_reg.state == RX_ACK_A) || (r_reg.state == RX_ACK_S)
		|| (r_reg.state == RX_ACK_D);
	assign ctrl    = r_reg.ctrl;

	property p_rst_ctrl;
		@(posedge clk) $rose(rst_n) |-> ctrl == `CSC_CTRL_RST;
	endproperty
	a_rst_ctrl: assert property (p_rst_ctrl)
		else $error("control register not at reset value");

	property p_ctrl_write;
		@(posedge clk) disable iff (!rst_n)
		$changed(ctrl) |-> $past(r_reg.state) == RX_DATA
			&& $past(r_reg.sub) == `CSC_SUB_CTRL;
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control register changed outside a write");

endmodule
`default_nettype wire

//--- design/csc_formatter.sv
// input formatter and control of the colour space converter
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"

module csc_formatter
	import csc_pkg::*;
(
	input  wire logic       CLK_SYS,
	input  wire logic       RSTN,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	input  wire logic       ADDR_SEL,
	input  wire logic [7:0] LUMA_INPUT_BUS,
	input  wire logic [7:0] CHROMA_INPUT_BUS,
	input  wire logic [7:0] RED_DIFFERENCE_INPUT,
	input  wire logic       CLOCK_QUALIFIER,
	input  wire logic       LINE_ACTIVE_REFERENCE,
	input  wire logic       CLOCK_SOURCE_SELECT,
	input  wire logic       LOOKUP_TABLE_ENABLE,
	input  wire logic       FAST_OUTPUT_ENABLE_N,
	output logic [7:0]      Y_OUT,
	output logic [7:0]      CB_OUT,
	output logic [7:0]      CR_OUT,
	output logic            SAMPLE_VALID,
	output logic [3:0]      FUNCTIONAL_MODE,
	output logic [1:0]      FILTER_SELECT,
	output logic            MATRIX_ON,
	output logic            LOOKUP_TABLE_ON,
	output logic            PIXEL_OUTPUT_BUS_OE
);

	fmt_regs_t  s_reg;
	fmt_regs_t  s_next;
	logic [7:0] ctrl;
	logic [2:0] fmt;
	logic       mat_en;
	logic       blank_ctl;
	logic       ser_oe;
	logic       capture;
	logic       line_start;
	logic       force_blank;

	// functional mode: filter base plus matrix, plus two with the tables
	function automatic logic [3:0] mode_of(input logic [2:0] f,
		input logic m, input logic l);
		logic [3:0] base;
		base = (f < 3'h2) ? `CSC_MODE_411 :
			(f < 3'h4) ? `CSC_MODE_422 : `CSC_MODE_444;
		return base + {3'h0, m} + {2'h0, l, 1'b0};
	endfunction

	// control register arrives over the two-wire serial port
	csc_ctrl_rx u_rx (
		.clk      (CLK_SYS),
		.rst_n    (RSTN),
		.scl_in   (SCL),
		.sda_in   (SDA_IN),
		.addr_sel (ADDR_SEL),
		.sda_out  (SDA_OUT),
		.sda_oe   (SDA_OE),
		.ctrl     (ctrl)
	);

	// decoded control fields
	assign fmt       = ctrl[`CSC_FMT_MSB:`CSC_FMT_LSB];
	assign mat_en    = ctrl[`CSC_MAT_BIT];
	assign blank_ctl = ctrl[`CSC_BLANK_BIT];
	assign ser_oe    = ctrl[`CSC_SOE_BIT];

	// unqualified source treats the qualifier as always high
	assign capture     = s_reg.src_s[1] ? s_reg.qual_s[1] : 1'b1;
	assign line_start  = s_reg.line_active_reference_s[1] & ~s_reg.line_active_reference_d;
	// latches forced while outside the active line when blanking control is 0
	assign force_blank = ~blank_ctl & ~s_reg.line_active_reference_s[1];

	// next state: synchronisers, demultiplexer and mode decode
	always_comb begin
		s_next         = s_reg;
		s_next.line_active_reference_s  = {s_reg.line_active_reference_s[0], LINE_ACTIVE_REFERENCE};
		s_next.line_active_reference_d  = s_reg.line_active_reference_s[1];
		s_next.qual_s  = {s_reg.qual_s[0], CLOCK_QUALIFIER};
		s_next.src_s   = {s_reg.src_s[0], CLOCK_SOURCE_SELECT};
		s_next.lut_s   = {s_reg.lut_s[0], LOOKUP_TABLE_ENABLE};
		s_next.oen_s   = {s_reg.oen_s[0], FAST_OUTPUT_ENABLE_N};
		s_next.luma_s1 = LUMA_INPUT_BUS;
		s_next.luma_s2 = s_reg.luma_s1;
		s_next.chr_s1  = CHROMA_INPUT_BUS;
		s_next.chr_s2  = s_reg.chr_s1;
		s_next.red_s1  = RED_DIFFERENCE_INPUT;
		s_next.red_s2  = s_reg.red_s1;
		s_next.valid   = 1'b0;

		// mode and path selection follow register and fast pin
		s_next.mode    = mode_of(fmt, mat_en, s_reg.lut_s[1]);
		s_next.filt    = (fmt < 3'h2) ? 2'h1 : (fmt < 3'h4) ? 2'h2 : 2'h0;
		s_next.mat_on  = mat_en;
		s_next.lut_on  = s_reg.lut_s[1];
		// both enables must agree before the bus is driven
		s_next.oe      = ser_oe & ~s_reg.oen_s[1];

		if (capture) begin
			s_next.valid = 1'b1;
			// phase restarts when a sample is captured in the line_start cycle
			s_next.phase = line_start ? 2'h1 : s_reg.phase + 2'h1;
			if (force_blank) begin
				s_next.y_out  = `CSC_Y_BLANK;
				s_next.cb_out = `CSC_C_BLANK;
				s_next.cr_out = `CSC_C_BLANK;
			end else begin
				s_next.y_out = s_reg.luma_s2;
				unique case (fmt)
					3'h0: begin
						// two U and two V bits per sample, msb first
						s_next.u_acc = {s_reg.u_acc[3:0], s_reg.chr_s2[7:6]};
						s_next.v_acc = {s_reg.v_acc[3:0], s_reg.chr_s2[5:4]};
						if (!line_start && s_reg.phase == 2'h3) begin
							s_next.cb_out = {s_reg.u_acc, s_reg.chr_s2[7:6]};
							s_next.cr_out = {s_reg.v_acc, s_reg.chr_s2[5:4]};
						end
					end
					3'h1: begin
						// blue on phase 0, red on phase 2
						if (line_start || s_reg.phase == 2'h0)
							s_next.cb_out = s_reg.chr_s2;
						else if (s_reg.phase == 2'h2)
							s_next.cr_out = s_reg.chr_s2;
					end
					3'h2: begin
						// blue on even samples, red on odd
						if (line_start || !s_reg.phase[0])
							s_next.cb_out = s_reg.chr_s2;
						else
							s_next.cr_out = s_reg.chr_s2;
					end
					3'h3: begin
						// both components on even samples only
						if (line_start || !s_reg.phase[0]) begin
							s_next.cb_out = s_reg.chr_s2;
							s_next.cr_out = s_reg.red_s2;
						end
					end
					default: begin
						// full-rate parallel, also covers unused codes
						s_next.cb_out = s_reg.chr_s2;
						s_next.cr_out = s_reg.red_s2;
					end
				endcase
			end
		end
	end

	// one register bank for all formatter state
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			s_reg        <= '0;
			s_reg.y_out  <= `CSC_Y_BLANK;
			s_reg.cb_out <= `CSC_C_BLANK;
			s_reg.cr_out <= `CSC_C_BLANK;
			s_reg.oen_s  <= 2'h3;
			s_reg.mode   <= `CSC_MODE_444;
		end else begin
			s_reg <= s_next;
		end
	end

	// all data and control outputs come from flip-flops
	assign Y_OUT               = s_reg.y_out;
	assign CB_OUT              = s_reg.cb_out;
	assign CR_OUT              = s_reg.cr_out;
	assign SAMPLE_VALID        = s_reg.valid;
	assign FUNCTIONAL_MODE     = s_reg.mode;
	assign FILTER_SELECT       = s_reg.filt;
	assign MATRIX_ON           = s_reg.mat_on;
	assign LOOKUP_TABLE_ON     = s_reg.lut_on;
	assign PIXEL_OUTPUT_BUS_OE = s_reg.oe;

	property p_oe_on;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(ser_oe && !s_reg.oen_s[1]) |=> PIXEL_OUTPUT_BUS_OE;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("output bus not enabled");

	property p_oe_off;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(!ser_oe || s_reg.oen_s[1]) |=> !PIXEL_OUTPUT_BUS_OE;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output bus driven while disabled");

	property p_blank;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(capture && !blank_ctl && !s_reg.line_active_reference_s[1]) |=>
			Y_OUT == `CSC_Y_BLANK && CB_OUT == `CSC_C_BLANK
			&& CR_OUT == `CSC_C_BLANK && SAMPLE_VALID;
	endproperty
	a_blank: assert property (p_blank)
		else $error("inputs not forced to blank levels");

	property p_mode_bypass;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(fmt == 3'h4 && !mat_en && !s_reg.lut_s[1]) ##1
			(fmt == 3'h4 && !mat_en && !s_reg.lut_s[1])
			|-> FUNCTIONAL_MODE == 4'h9 && FILTER_SELECT == 2'h0;
	endproperty
	a_mode_bypass: assert property (p_mode_bypass)
		else $error("pass-through mode not selected");

	property p_mode_matrix;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(fmt < 3'h2 && mat_en && s_reg.lut_s[1])
			|=> FUNCTIONAL_MODE == 4'h4 || $changed(ctrl)
			|| $changed(s_reg.lut_s[1]);
	endproperty
	a_mode_matrix: assert property (p_mode_matrix)
		else $error("wrong mode for 4:1:1 with matrix and tables");

	property p_lut;
		@(posedge CLK_SYS) disable iff (!RSTN)
		$rose(s_reg.lut_s[1]) |=> LOOKUP_TABLE_ON && FUNCTIONAL_MODE
			== mode_of($past(fmt), $past(mat_en), 1'b1);
	endproperty
	a_lut: assert property (p_lut)
		else $error("lookup tables not switched in");

	property p_qualified;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(s_reg.src_s[1] && !s_reg.qual_s[1]) |=> !SAMPLE_VALID;
	endproperty
	a_qualified: assert property (p_qualified)
		else $error("sample taken without qualifier");

	property p_parallel;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(capture && fmt == 3'h4 && blank_ctl) |=>
			Y_OUT == $past(s_reg.luma_s2) && CR_OUT == $past(s_reg.red_s2)
			&& CB_OUT == $past(s_reg.chr_s2);
	endproperty
	a_parallel: assert property (p_parallel)
		else $error("parallel sample not passed through");

	property p_alt_red;
		@(posedge CLK_SYS) disable iff (!RSTN)
		(capture && fmt == 3'h2 && blank_ctl && !line_start
			&& s_reg.phase[0]) |=> CR_OUT == $past(s_reg.chr_s2)
			&& $stable(CB_OUT);
	endproperty
	a_alt_red: assert property (p_alt_red)
		else $error("red difference not taken on odd sample");

endmodule
`default_nettype wire

//--- pkg/csc_cfg.svh
// constants of the colour space converter input formatter and control
//
// Overview of operation
// - reset loads input_format_select (D0-D2) with 4, the 4:4:4 format.
// - reset sets serial_output_enable 1, matrix_enable 0, blanking 0.
// - mode from format code, matrix_enable and lookup_table_enable: 1/5/9, plus one with matrix, plus two with tables.
// - lookup_table_enable pin high applies gamma tables, low bypasses them.
// - blanking control 0 forces Y 16, Cb/Cr 128 while line ref low.
// - clock source 1 uses qualifier; 0 runs unqualified up to 16 MHz.
// - output bus driven only with serial enable 1 and fast enable low.
// - format 0 chroma is 4-bit U/V pairs on lines 37..34, MSB first.
// - formats 0 and 2 capture on qualified edges, clock twice sample rate.
// - format 1 chroma: blue at sample 0, red at sample 2, period four.
// - format 2 chroma alternates blue and red each sample, blue first.
// - format 3 blue on chroma bus, red on red input, even samples.
// - format 4 carries Y, Cb, Cr in parallel at full rate.
// - mode 9 passes input through; mode 10 adds matrix without filter.
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

`define CSC_SUB_CTRL     8'h00
`define CSC_FMT_MSB      2
`define CSC_FMT_LSB      0
`define CSC_MAT_BIT      3
`define CSC_BLANK_BIT    4
`define CSC_SOE_BIT      5
`define CSC_CTRL_RST     8'h24
`define CSC_Y_BLANK      8'h10
`define CSC_C_BLANK      8'h80
`define CSC_SLV_BASE     6'h2b
`define CSC_BYTE_BITS    4'h8
`define CSC_MODE_411     4'h1
`define CSC_MODE_422     4'h5
`define CSC_MODE_444     4'h9
`define CSC_MAX_RATE_MHZ 16

`endif

//--- pkg/csc_pkg.sv
// types of the colour space converter input formatter and control
package csc_pkg;

	// serial control receiver states, gray along the write path
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_ADDR  = 3'b001,
		RX_ACK_A = 3'b011,
		RX_SUB   = 3'b010,
		RX_ACK_S = 3'b110,
		RX_DATA  = 3'b111,
		RX_ACK_D = 3'b101
	} rx_state_t;

	typedef struct packed {
		logic       scl_s1;
		logic       scl_s2;
		logic       scl_s3;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_s3;
		logic       adr_s1;
		logic       adr_s2;
		rx_state_t  state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] sub;
		logic [7:0] ctrl;
	} rx_regs_t;

	typedef struct packed {
		logic [1:0] line_active_reference_s;
		logic       line_active_reference_d;
		logic [1:0] qual_s;
		logic [1:0] src_s;
		logic [1:0] lut_s;
		logic [1:0] oen_s;
		logic [7:0] luma_s1;
		logic [7:0] luma_s2;
		logic [7:0] chr_s1;
		logic [7:0] chr_s2;
		logic [7:0] red_s1;
		logic [7:0] red_s2;
		logic [1:0] phase;
		logic [5:0] u_acc;
		logic [5:0] v_acc;
		logic [7:0] y_out;
		logic [7:0] cb_out;
		logic [7:0] cr_out;
		logic       valid;
		logic [3:0] mode;
		logic [1:0] filt;
		logic       mat_on;
		logic       lut_on;
		logic       oe;
	} fmt_regs_t;

endpackage

//--- tb/csc_video_source.sv
// video source model: tagged samples in every input format
`timescale 1ns/1ps
`default_nettype none

module csc_video_source (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       qual_mode,
	input  wire logic [2:0] fmt,
	output logic [7:0]      luma,
	output logic [7:0]      chroma,
	output logic [7:0]      red,
	output logic            qual,
	output logic            line_active_reference,
	output logic            cap,
	output logic [3:0]      k
);
	// colour values inside the coding range, neither of them colourless
	localparam logic [7:0] CBV = 8'h5a;
	localparam logic [7:0] CRV = 8'ha6;
	logic       half;
	logic [7:0] junk;
	logic [3:0] sh;

	// slot counter: two clocks a slot when qualified, twelve slots a line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			k    <= 4'h0;
			half <= 1'b0;
		end else begin
			half <= qual_mode & ~half;
			if (!qual_mode || half)
				k <= (k == 4'hb) ? 4'h0 : k + 4'h1;
		end
	end

	// unused lanes carry a changing pattern so stale data never matches
	always_comb begin
		sh     = 4'h6 - {1'b0, k[1:0], 1'b0};
		junk   = 8'he1 ^ {4'h0, k};
		qual   = qual_mode & half;
		cap    = ~qual_mode | half;
		line_active_reference   = (k < 4'h8);
		luma   = 8'h30 + {4'h0, k};
		red    = junk;
		chroma = CBV;
		case (fmt)
		3'd0: chroma = {2'(CBV >> sh), 2'(CRV >> sh), k};
		3'd1: chroma = k[0] ? junk : (k[1] ? CRV : CBV);
		3'd2: chroma = k[0] ? CRV : CBV;
		3'd3: begin
			chroma = k[0] ? junk : CBV;
			red    = k[0] ? junk : CRV;
		end
		default: red = CRV;
		endcase
	end
endmodule
`default_nettype wire

//--- tb/test_colour_space_input_formatter_control.sv
// self-checking bench of the colour space converter input formatter
`timescale 1ns/1ps
`default_nettype none
`include "csc_cfg.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_colour_space_input_formatter_control;
	localparam logic [7:0]  CBV   = 8'h5a;
	localparam logic [7:0]  CRV   = 8'ha6;
	localparam logic [23:0] BLANK = {`CSC_Y_BLANK, `CSC_C_BLANK, `CSC_C_BLANK};
	logic       clk, rstn, scl, sda_drv, addr_sel, qsel, lut, oen, chk_on;
	logic       cur_blank, qual, line_active_reference, cap, sda_o, sda_oe, valid;
	logic       mat_on, lut_on, pix_oe;
	logic [2:0] cur_fmt, capd;
	logic [7:0] luma, chroma, red, y_o, cb_o, cr_o;
	logic [3:0] src_k, mode, idx;
	logic [3:0] kd [3];
	logic [1:0] filt;
	int         fail_count, comparisons, n_cap, n_val, cycles;
	// open-drain data line with pull-up, low when either side pulls
	wire logic  sda_w = sda_drv & ~(sda_oe & ~sda_o);

	csc_formatter dut (
		.CLK_SYS(clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda_w),
		.SDA_OUT(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
		.LUMA_INPUT_BUS(luma), .CHROMA_INPUT_BUS(chroma),
		.RED_DIFFERENCE_INPUT(red), .CLOCK_QUALIFIER(qual),
		.LINE_ACTIVE_REFERENCE(line_active_reference), .CLOCK_SOURCE_SELECT(qsel),
		.LOOKUP_TABLE_ENABLE(lut), .FAST_OUTPUT_ENABLE_N(oen),
		.Y_OUT(y_o), .CB_OUT(cb_o), .CR_OUT(cr_o), .SAMPLE_VALID(valid),
		.FUNCTIONAL_MODE(mode), .FILTER_SELECT(filt), .MATRIX_ON(mat_on),
		.LOOKUP_TABLE_ON(lut_on), .PIXEL_OUTPUT_BUS_OE(pix_oe)
	);
	csc_video_source src (
		.clk(clk), .rst_n(rstn), .qual_mode(qsel), .fmt(cur_fmt),
		.luma(luma), .chroma(chroma), .red(red), .qual(qual),
		.line_active_reference(line_active_reference), .cap(cap), .k(src_k)
	);

	// free-running clock and a guard against hangs
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end

	// tags of samples in flight, aligned with the three-edge pipeline
	always @(posedge clk) begin
		kd[0] <= src_k;
		kd[1] <= kd[0];
		kd[2] <= kd[1];
		capd  <= {capd[1:0], cap};
	end

	// inside the active line, chroma is judged at phase 3, where every format is complete, and on every sample in format 4
	always @(negedge clk) begin
		if (chk_on) begin
			n_cap += capd[2];
			n_val += (valid === 1'b1);
			if (valid === 1'b1) begin
				idx = kd[2];
				if (idx >= 4'h8 && !cur_blank)
					`CHK({y_o, cb_o, cr_o}, BLANK)
				else begin
					`CHK(y_o, 8'h30 + {4'h0, idx})
					if (idx < 4'h8 && (idx[1:0] == 2'd3 || cur_fmt == 3'd4))
						`CHK({cb_o, cr_o}, {CBV, CRV})
				end
			end
		end
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// both serial lines set together, then held for four clocks
	task automatic line(input logic c, input logic d);
		scl <= c;
		sda_drv <= d;
		tick(4);
	endtask

	// eight bits msb first, then a released ack bit sampled mid-high
	task automatic sbyte(input logic [7:0] v, output logic ak);
		logic [8:0] w;
		w = {v, 1'b1};
		for (int b = 8; b >= 0; b--) begin
			line(1'b0, w[b]);
			line(1'b1, w[b]);
			ak = sda_w;
			line(1'b1, w[b]);
			line(1'b0, w[b]);
		end
	endtask

	task automatic wrt(input logic [7:0] a, input logic [7:0] d, input logic ok);
		logic ak;
		tick(1);
		line(1'b1, 1'b1);
		line(1'b1, 1'b0);
		line(1'b0, 1'b0);
		sbyte(a, ak);
		`CHK(ak, ~ok)
		if (ok) begin
			sbyte(`CSC_SUB_CTRL, ak);
			sbyte(d, ak);
			`CHK(ak, 1'b0)
			cur_fmt = d[2:0];
			cur_blank = d[4];
		end
		line(1'b0, 1'b0);
		line(1'b1, 1'b0);
		line(1'b1, 1'b1);
		tick(8);
	endtask

	task automatic cfg(input logic [7:0] d);
		wrt({`CSC_SLV_BASE, addr_sel, 1'b0}, d, 1'b1);
	endtask

	// checks open in slot 11, the last of a line, so the phase count begins afresh at the next line start
	task automatic run(input int n);
		n_cap = 0;
		n_val = 0;
		for (int j = 0; j < 40 && src_k != 4'hb; j++)
			tick(1);
		chk_on <= 1'b1;
		tick(n);
		chk_on <= 1'b0;
		tick(4);
		`CHK(n_val, n_cap)
	endtask

	function automatic logic [5:0] exp_mf(input int f, input int m, input int l);
		return {(f < 2 ? `CSC_MODE_411 : f < 4 ? `CSC_MODE_422 : `CSC_MODE_444)
			+ 4'(m + 2 * l), f < 2 ? 2'd1 : f < 4 ? 2'd2 : 2'd0};
	endfunction

	// main sequence
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		scl = 1'b1;
		sda_drv = 1'b1;
		addr_sel = 1'b1;
		qsel = 1'b0;
		lut = 1'b0;
		oen = 1'b0;
		chk_on = 1'b0;
		cur_fmt = 3'd4;
		cur_blank = 1'b0;
		tick(3);
		@(negedge clk);
		`CHK(mode, `CSC_MODE_444)
		`CHK({filt, mat_on}, 3'b000)
		tick(1);
		rstn <= 1'b1;
		tick(6);
		@(negedge clk);
		`CHK(pix_oe, 1'b1)
		run(30);
		wrt({`CSC_SLV_BASE, ~addr_sel, 1'b0}, 8'h3b, 1'b0);
		`CHK(mode, `CSC_MODE_444)
		for (int f = 0; f < 5; f++) begin
			for (int m = 0; m < 2; m++) begin
				cfg({4'b0011, m[0], f[2:0]});
				for (int l = 0; l < 2; l++) begin
					lut <= l[0];
					tick(5);
					@(negedge clk);
					`CHK({mode, filt, mat_on, lut_on}, {exp_mf(f, m, l), m[0], l[0]})
					tick(1);
				end
			end
		end
		for (int s = 0; s < 2; s++) begin
			cfg({2'b00, s[0], 5'b10100});
			for (int n = 0; n < 2; n++) begin
				oen <= n[0];
				tick(5);
				@(negedge clk);
				`CHK(pix_oe, s[0] & ~n[0])
				tick(1);
			end
		end
		oen <= 1'b0;
		qsel <= 1'b1;
		for (int f = 0; f < 5; f++) begin
			cfg({5'b00110, f[2:0]});
			run(60);
		end
		cfg(8'h22);
		run(60);
		results();
	end
endmodule
`default_nettype wire
